// ---- stc_timer16.sv ----
`timescale 1ns/10ps
`default_nettype none
module stc_timer16
  import stc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic ext_count_i,
  input wire logic sec_osc_i,
  input wire logic special_trig_i,
  input wire logic [1:0] osc_pin_i,
  output logic [1:0] osc_pin_o,
  output logic [1:0] osc_pin_oe_o,
  output logic [4:0] ccp_timebase_o,
  output logic irq_o
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] oscp;
    logic [15:0] cnt;
    logic [7:0] hibuf;
    logic flag;
    logic mask;
    logic [7:0] rdata;
    logic [1:0] phase;
    logic armed;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
  } stc_state_t;

  stc_state_t r;
  stc_state_t n;
  logic rst_s1_r;
  logic rst_n;

  logic wide;
  logic run;
  logic src_ext;
  logic bypass;
  logic async_mode;
  logic osc_en;
  logic [1:0] ps_code;
  logic rise_ext;
  logic fall_ext;
  logic rise_osc;
  logic fall_osc;
  logic rise;
  logic fall;
  logic instr_tick;
  logic raw_tick;
  logic ps_tick;
  logic wr_lo;
  logic wr_hi;
  logic cnt_wr;
  logic trig_ok;
  logic ovf;
  logic [7:0] rd_mux;

  // Reset release through two flops
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  assign wide = r.ctrl[CTRL_WIDE];
  assign run = r.ctrl[CTRL_RUN];
  assign src_ext = r.ctrl[CTRL_SRC];
  assign bypass = r.ctrl[CTRL_SYNC_BYP];
  assign ps_code = {r.ctrl[CTRL_PS_HI], r.ctrl[CTRL_PS_LO]};
  assign osc_en = r.oscp[OSC_EN_BIT];
  // Mode: timer, synchronous counter or asynchronous counter
  assign async_mode = src_ext & bypass;

  // Each source has its own synchroniser, so no logic ever sees a raw pin
  stc_edge_det u_edge_ext (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .pin_i(ext_count_i),
    .bypass_i(bypass),
    .rise_o(rise_ext),
    .fall_o(fall_ext)
  );

  stc_edge_det u_edge_osc (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .pin_i(sec_osc_i),
    .bypass_i(bypass),
    .rise_o(rise_osc),
    .fall_o(fall_osc)
  );

  // Oscillator counts when enabled, otherwise the count pin
  assign rise = osc_en ? rise_osc : rise_ext;
  assign fall = osc_en ? fall_osc : fall_ext;

  assign instr_tick = (r.phase == INSTR_LAST);
  assign raw_tick = src_ext ? (rise & r.armed) : instr_tick;

  assign wr_lo = wr_i & (addr_i == ADDR_CNT_LO);
  assign wr_hi = wr_i & (addr_i == ADDR_CNT_HI);
  assign cnt_wr = wr_lo | wr_hi;

  stc_prescale u_ps (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .clr_i(wr_lo),
    .tick_i(raw_tick & run),
    .code_i(ps_code),
    .tick_o(ps_tick)
  );

  // Trigger only acts in timer and synchronous counter modes
  assign trig_ok = special_trig_i & ~async_mode & ~cnt_wr;
  assign ovf = ps_tick & (r.cnt == CNT_MAX) & ~cnt_wr;

  always_comb begin
    case (addr_i)
      ADDR_CTRL: rd_mux = r.ctrl;
      ADDR_CNT_LO: rd_mux = r.cnt[7:0];
      ADDR_CNT_HI: rd_mux = wide ? r.hibuf : r.cnt[15:8];
      ADDR_OSC_PORT: rd_mux = r.oscp;
      ADDR_IRQ_STATUS: rd_mux = 8'(r.flag) << IRQ_OVF_BIT;
      ADDR_IRQ_MASK: rd_mux = 8'(r.mask) << IRQ_OVF_BIT;
      ADDR_PORT_IN: rd_mux = osc_en ? 8'h00 : {6'h00, r.pin_s2};
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    n = r;
    n.phase = r.phase + 2'h1;
    n.pin_s1 = osc_pin_i;
    n.pin_s2 = r.pin_s1;
    n.rdata = 8'h00;

    // Only edges after the first falling edge count
    if (!src_ext) begin
      n.armed = 1'b0;
    end else if (fall) begin
      n.armed = 1'b1;
    end

    if (ps_tick) begin
      n.cnt = r.cnt + 16'h1;
    end
    if (trig_ok) begin
      n.cnt = 16'h0000;
    end
    if (wr_hi) begin
      if (wide) begin
        n.hibuf = wdata_i;
      end else begin
        n.cnt[15:8] = wdata_i;
      end
    end
    if (wr_lo) begin
      n.cnt = wide ? {r.hibuf, wdata_i} : {r.cnt[15:8], wdata_i};
    end

    if (wr_i && addr_i == ADDR_CTRL) begin
      n.ctrl = wdata_i;
    end
    if (wr_i && addr_i == ADDR_OSC_PORT) begin
      n.oscp = wdata_i;
    end
    if (wr_i && addr_i == ADDR_IRQ_MASK) begin
      n.mask = wdata_i[IRQ_OVF_BIT];
    end
    // Write one clears; a new overflow wins
    if (wr_i && addr_i == ADDR_IRQ_STATUS && wdata_i[IRQ_OVF_BIT]) begin
      n.flag = 1'b0;
    end
    if (ovf) begin
      n.flag = 1'b1;
    end

    if (rd_i) begin
      n.rdata = rd_mux;
      if (wide && addr_i == ADDR_CNT_LO) begin
        n.hibuf = r.cnt[15:8];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.ctrl <= CTRL_RST;
      r.oscp <= OSC_PORT_RST;
    end else begin
      r <= n;
    end
  end

  assign rdata_o = r.rdata;
  assign irq_o = r.flag & r.mask;
  assign ccp_timebase_o = stc_route({r.ctrl[CTRL_TB_HI], r.ctrl[CTRL_TB_LO]});
  assign osc_pin_o = r.oscp[PORT_OUT_LO+1:PORT_OUT_LO];
  // Direction bit one means input
  assign osc_pin_oe_o = osc_en ? 2'b00 : ~r.oscp[DIR_LO+1:DIR_LO];

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n);

  wrap_flag_a: assert property (
    (ps_tick && r.cnt == CNT_MAX && !cnt_wr && !trig_ok) |=> (r.cnt == 16'h0000 && r.flag))
    else $error("wrap did not clear count or set flag");

  irq_gate_a: assert property (
    (ovf && r.mask && !(wr_i && addr_i == ADDR_IRQ_MASK)) |=> irq_o)
    else $error("enabled overflow did not raise interrupt");

  no_irq_masked_a: assert property (
    !r.mask |-> !irq_o) else $error("interrupt raised while disabled");

  trig_reset_a: assert property (
    (trig_ok && !ovf && !r.flag && !(wr_i && addr_i == ADDR_IRQ_STATUS))
      |=> (r.cnt == 16'h0000 && !r.flag)) else $error("trigger reset wrong");

  stop_hold_a: assert property (
    (!run && !cnt_wr && !special_trig_i) |=> $stable(r.cnt))
    else $error("stopped counter changed");

  wide_read_a: assert property (
    (rd_i && wide && addr_i == ADDR_CNT_LO) ##1 (!rd_i && !wr_i) ##1
      (rd_i && addr_i == ADDR_CNT_HI)
      |=> rdata_o == $past(r.cnt[15:8], 3)) else $error("buffered high byte mismatch");

  wide_write_a: assert property (
    (wr_hi && wide) ##1 (!wr_i && !rd_i) ##1 wr_lo
      |=> r.cnt == {$past(wdata_i, 3), $past(wdata_i)})
    else $error("wide write not loaded as one word");

  route_a: assert property (
    {r.ctrl[CTRL_TB_HI], r.ctrl[CTRL_TB_LO]} == 2'h2 |-> ccp_timebase_o == 5'h1c)
    else $error("time base routing wrong");

  pin_input_a: assert property (
    osc_en |-> (osc_pin_oe_o == 2'b00 && (rd_mux[1:0] == 2'b00 || addr_i != ADDR_PORT_IN)))
    else $error("oscillator pins not forced to input");

  read_late_a: assert property (
    (rd_i && addr_i == ADDR_CNT_LO) |=> rdata_o == $past(r.cnt[7:0]))
    else $error("low byte read data wrong");

  run_count_a: assert property (
    (ps_tick && !cnt_wr && !trig_ok) |=> r.cnt == $past(r.cnt) + 16'h1)
    else $error("running counter did not advance by one");

  narrow_hi_a: assert property (
    (wr_hi && !wide) |=> r.cnt[15:8] == $past(wdata_i))
    else $error("narrow high byte write lost");

  narrow_lo_a: assert property (
    (wr_lo && !wide) |=> r.cnt == {$past(r.cnt[15:8]), $past(wdata_i)})
    else $error("narrow low byte write wrong");

  hi_buffer_only_a: assert property (
    (wr_hi && wide && !ps_tick) |=> $stable(r.cnt))
    else $error("wide high write reached live count");

  hibuf_capture_a: assert property (
    (rd_i && wide && addr_i == ADDR_CNT_LO) |=> r.hibuf == $past(r.cnt[15:8]))
    else $error("low read did not capture high byte");

  async_trig_a: assert property (
    (special_trig_i && async_mode && !cnt_wr && !ps_tick) |=> $stable(r.cnt))
    else $error("trigger acted in asynchronous mode");

  flag_source_a: assert property (
    $rose(r.flag) |-> $past(r.cnt) == CNT_MAX)
    else $error("flag set without a wrap");

  flag_clear_a: assert property (
    (wr_i && addr_i == ADDR_IRQ_STATUS && wdata_i[IRQ_OVF_BIT] && !ovf) |=> !r.flag)
    else $error("status write did not clear flag");

  mask_write_a: assert property (
    (wr_i && addr_i == ADDR_IRQ_MASK) |=> r.mask == $past(wdata_i[IRQ_OVF_BIT]))
    else $error("mask write lost");

  port_zero_a: assert property (
    (rd_i && osc_en && addr_i == ADDR_PORT_IN) |=> rdata_o == 8'h00)
    else $error("oscillator pins read nonzero");

  rdata_idle_a: assert property (
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data outside answer cycle");
endmodule
`default_nettype wire

// ---- stc_pkg.sv ----
package stc_pkg;
  localparam int unsigned ADDR_W = 3;
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_CNT_LO = 3'h1;
  localparam logic [2:0] ADDR_CNT_HI = 3'h2;
  localparam logic [2:0] ADDR_OSC_PORT = 3'h3;
  localparam logic [2:0] ADDR_IRQ_STATUS = 3'h4;
  localparam logic [2:0] ADDR_IRQ_MASK = 3'h5;
  localparam logic [2:0] ADDR_PORT_IN = 3'h6;

  localparam int unsigned CTRL_WIDE = 7;
  localparam int unsigned CTRL_TB_HI = 6;
  localparam int unsigned CTRL_PS_HI = 5;
  localparam int unsigned CTRL_PS_LO = 4;
  localparam int unsigned CTRL_TB_LO = 3;
  localparam int unsigned CTRL_SYNC_BYP = 2;
  localparam int unsigned CTRL_SRC = 1;
  localparam int unsigned CTRL_RUN = 0;

  localparam int unsigned OSC_EN_BIT = 0;
  localparam int unsigned DIR_LO = 1;
  localparam int unsigned PORT_OUT_LO = 3;
  localparam int unsigned IRQ_OVF_BIT = 1;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] OSC_PORT_RST = 8'h06;
  localparam logic [15:0] CNT_MAX = 16'hffff;

  // Instruction cycle is four device clocks
  localparam int unsigned SYS_CLK_HZ = 40000000;
  localparam int unsigned INSTR_HZ = 10000000;
  localparam logic [1:0] INSTR_LAST = 2'(SYS_CLK_HZ / INSTR_HZ - 1);

  localparam logic [4:0] ROUTE_ALL = 5'h1f;
  localparam logic [4:0] ROUTE_TWO_UP = 5'h1e;
  localparam logic [4:0] ROUTE_THREE_UP = 5'h1c;
  localparam logic [4:0] ROUTE_NONE = 5'h00;

  function automatic logic [4:0] stc_route(input logic [1:0] sel);
    case (sel)
      2'h3: stc_route = ROUTE_ALL;
      2'h2: stc_route = ROUTE_THREE_UP;
      2'h1: stc_route = ROUTE_TWO_UP;
      default: stc_route = ROUTE_NONE;
    endcase
  endfunction

  function automatic logic [2:0] stc_ps_mask(input logic [1:0] code);
    case (code)
      2'h3: stc_ps_mask = 3'h7;
      2'h2: stc_ps_mask = 3'h3;
      2'h1: stc_ps_mask = 3'h1;
      default: stc_ps_mask = 3'h0;
    endcase
  endfunction
endpackage

// ---- stc_edge_det.sv ----
`timescale 1ns/10ps
`default_nettype none
module stc_edge_det
  import stc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  input wire logic bypass_i,
  output logic rise_o,
  output logic fall_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic prev;
  } stc_edge_t;

  stc_edge_t r;
  stc_edge_t n;
  logic lvl;

  always_comb begin
    n = r;
    n.s1 = pin_i;
    n.s2 = r.s1;
    n.s3 = r.s2;
    // Synchronous mode adds a retiming stage
    lvl = bypass_i ? r.s2 : r.s3;
    n.prev = lvl;
  end

  assign rise_o = lvl & ~r.prev;
  assign fall_o = ~lvl & r.prev;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  single_rise_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rise_o |=> !rise_o) else $error("rise pulse longer than one cycle");
endmodule
`default_nettype wire

// ---- stc_prescale.sv ----
`timescale 1ns/10ps
`default_nettype none
module stc_prescale
  import stc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clr_i,
  input wire logic tick_i,
  input wire logic [1:0] code_i,
  output logic tick_o
);
  typedef struct packed {
    logic [2:0] cnt;
  } stc_ps_t;

  stc_ps_t r;
  stc_ps_t n;
  logic [2:0] msk;

  always_comb begin
    n = r;
    msk = stc_ps_mask(code_i);
    if (clr_i) begin
      n.cnt = 3'h0;
    end else if (tick_i) begin
      n.cnt = (r.cnt & msk) == msk ? 3'h0 : r.cnt + 3'h1;
    end
  end

  assign tick_o = tick_i & ~clr_i & ((r.cnt & msk) == msk);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  div_eight_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (code_i == 2'h3 && tick_o) |-> r.cnt == 3'h7) else $error("divide by eight too early");
endmodule
`default_nettype wire

// ---- stc_ext_src.sv ----
`timescale 1ns/10ps
`default_nettype none
module stc_ext_src (
  input wire logic sys_clk_i,
  output logic ext_count_o,
  output logic sec_osc_o
);
  initial begin
    ext_count_o = 1'b0;
    sec_osc_o = 1'b0;
  end

  // Idle low between bursts, w device clocks per level
  task automatic pulses(input int n, input bit osc, input int w);
    for (int i = 0; i < n; i++) begin
      repeat (w) @(posedge sys_clk_i);
      if (osc) begin
        sec_osc_o <= 1'b1;
      end else begin
        ext_count_o <= 1'b1;
      end
      repeat (w) @(posedge sys_clk_i);
      sec_osc_o <= 1'b0;
      ext_count_o <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ---- stc_timer16_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module stc_timer16_bench;
  import stc_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [ADDR_W-1:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic trig = 1'b0;
  logic [1:0] pin_in = 2'h0;
  logic [7:0] rdata;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;
  logic [4:0] tbase;
  logic irq;
  logic ext_cnt;
  logic sec_osc;
  int num_errors = 0;
  int comparisons = 0;
  logic [15:0] c;
  logic [15:0] held;
  int n;
  logic [15:0] v;
  logic [4:0] route [4] = '{5'h00, 5'h1e, 5'h1c, 5'h1f};

  stc_timer16 stc_timer16_i (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .ext_count_i(ext_cnt),
    .sec_osc_i(sec_osc), .special_trig_i(trig), .osc_pin_i(pin_in), .osc_pin_o(pin_out),
    .osc_pin_oe_o(pin_oe), .ccp_timebase_o(tbase), .irq_o(irq));
  stc_ext_src stc_ext_src_i (.sys_clk_i(sys_clk), .ext_count_o(ext_cnt), .sec_osc_o(sec_osc));

  always #12.5 sys_clk = ~sys_clk;

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Free-running phase of the tick makes exact counts unknowable
  task automatic near(input string nm, input int e, input logic [15:0] g);
    comparisons++;
    if ($isunknown(g) || int'(g) > e + 2 || int'(g) + 2 < e) begin
      num_errors++;
      $display("BAD %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge sys_clk);
    wr_s <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge sys_clk);
    rd_s <= 1'b0;
    @(posedge sys_clk);
    d = rdata;
  endtask

  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk($sformatf("register %0d", a), {8'h00, e}, {8'h00, d});
  endtask

  task automatic rdcnt(output logic [15:0] cv);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(ADDR_CNT_LO, lo);
    rd(ADDR_CNT_HI, hi);
    cv = {hi, lo};
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #(25 * 20000);
    num_errors++;
    finish_test();
  end

  initial begin
    void'($urandom(78454));
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rc(ADDR_CTRL, CTRL_RST);
    rc(ADDR_OSC_PORT, OSC_PORT_RST);
    rc(ADDR_IRQ_STATUS, 8'h00);
    rc(3'h7, 8'h00);
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_CTRL, {1'b0, s[1], 2'b00, s[0], 3'b000});
      chk("timebase", {11'h000, route[s]}, {11'h000, tbase});
    end
    $display("test routing done");
    v = 16'($urandom);
    wr(ADDR_CTRL, 8'h80);
    wr(ADDR_CNT_HI, v[15:8]);
    wr(ADDR_CNT_LO, v[7:0]);
    wr(ADDR_CTRL, 8'h00);
    rdcnt(c);
    chk("wide load", v, c);
    wr(ADDR_CTRL, 8'h80);
    wr(ADDR_CNT_HI, ~v[15:8]);
    wr(ADDR_CTRL, 8'h00);
    rc(ADDR_CNT_HI, v[15:8]);
    wr(ADDR_CTRL, 8'h80);
    rc(ADDR_CNT_LO, v[7:0]);
    rc(ADDR_CNT_HI, v[15:8]);
    wr(ADDR_CNT_HI, ~v[15:8]);
    rc(ADDR_CNT_HI, ~v[15:8]);
    $display("test wide done");
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_CNT_HI, 8'h00);
      wr(ADDR_CNT_LO, 8'h00);
      wr(ADDR_CTRL, {2'b00, 2'(p), 4'b0001});
      repeat (400) @(posedge sys_clk);
      wr(ADDR_CTRL, 8'h00);
      rdcnt(c);
      near("prescaled count", 400 / (4 << p), c);
      held = c;
      repeat (40) @(posedge sys_clk);
      rdcnt(c);
      chk("held count", held, c);
    end
    $display("test prescale done");
    wr(ADDR_IRQ_MASK, 8'h02);
    wr(ADDR_CNT_HI, 8'hff);
    wr(ADDR_CNT_LO, 8'hf0);
    wr(ADDR_CTRL, 8'h01);
    repeat (100) @(posedge sys_clk);
    wr(ADDR_CTRL, 8'h00);
    rdcnt(c);
    near("wrapped count", 100 / 4 - 16, c);
    rc(ADDR_IRQ_STATUS, 8'h02);
    chk("irq", 16'h1, {15'h0, irq});
    wr(ADDR_IRQ_MASK, 8'h00);
    chk("masked irq", 16'h0, {15'h0, irq});
    wr(ADDR_IRQ_STATUS, 8'h02);
    rc(ADDR_IRQ_STATUS, 8'h00);
    $display("test overflow done");
    wr(ADDR_CNT_HI, 8'h12);
    wr(ADDR_CNT_LO, 8'h34);
    trig <= 1'b1;
    @(posedge sys_clk);
    trig <= 1'b0;
    rdcnt(c);
    chk("trigger reset", 16'h0000, c);
    rc(ADDR_IRQ_STATUS, 8'h00);
    fork
      wr(ADDR_CNT_LO, 8'h55);
      begin
        trig <= 1'b1;
        @(posedge sys_clk);
        trig <= 1'b0;
      end
    join
    rdcnt(c);
    chk("write beats trigger", 16'h0055, c);
    $display("test trigger done");
    pin_in <= 2'(1 + $urandom_range(2));
    for (int m = 0; m < 3; m++) begin
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_CNT_HI, 8'h00);
      wr(ADDR_CNT_LO, 8'h00);
      wr(ADDR_OSC_PORT, (m == 2) ? 8'h01 : 8'h06);
      wr(ADDR_CTRL, (m == 1) ? 8'h07 : 8'h03);
      n = 3 + $urandom_range(4);
      stc_ext_src_i.pulses(n, m == 2, 4);
      repeat (10) @(posedge sys_clk);
      // Asynchronous mode ignores the special trigger
      if (m == 1) begin
        trig <= 1'b1;
        @(posedge sys_clk);
        trig <= 1'b0;
      end
      wr(ADDR_CTRL, 8'h00);
      rdcnt(c);
      chk("edge count", 16'(n - 1), c);
    end
    chk("osc pin enables", 16'h0, {14'h0, pin_oe});
    rc(ADDR_PORT_IN, 8'h00);
    wr(ADDR_OSC_PORT, 8'h18);
    repeat (4) @(posedge sys_clk);
    chk("pin enables", 16'h3, {14'h0, pin_oe});
    chk("pin values", 16'h3, {14'h0, pin_out});
    rc(ADDR_PORT_IN, {6'h00, pin_in});
    $display("test external done");
    finish_test();
  end
endmodule
`default_nettype wire
